// ===== verilog/wbus_write_port.sv
// write transaction engine and mastership hand-off on the multiplexed bus
//
// Function
// - each store is one single-beat transaction
// - same-page hint driven during address half-cycle
// - zero-wait write takes two bus cycles
// - write starts with strobe, address and control
// - rising edge drives address and latch strobe
// - second phase replaces address with held data
// - latch strobe drops before address leaves
// - fault ends write like acknowledge, no retry
// - acknowledge sampled each rising edge, waits otherwise
// - mastership request synchronised into arbiter
// - outside request has highest priority
// - grant on rising edge when bus free
// - grant waits for transaction in progress
// - bus pins float while outside master owns
// - capture, acknowledge, fault ignored while granted
// - request negated, grant drops next falling edge
// - drive resumes next rising edge, may write
// - no coherency for outside transfers
`timescale 1ns/1ps
`default_nettype none
module wbus_write_port
    import wbus_pkg::*;
#(
    parameter int unsigned PAGE_BIT = PAGE_LSB
) (
    input  wire logic      core_clk,                 // 125 MHz core clock
    input  wire logic      rst,                      // async reset, active high
    // write buffer side
    input  wire logic      wr_valid,                 // store pending
    input  wire wr_req_t   wr_req,                   // store address and data
    output logic           wr_taken_q,               // pulse: store accepted
    output logic           wr_done_q,                // pulse: write retired
    output logic           wr_fault_q,               // pulse: retired by fault
    // read engine side
    input  wire logic      rd_active,                // read owns the bus
    input  wire logic      rd_strobe_n,              // read strobe from read engine
    input  wire logic [1:0] diag_val,                // diagnostic pair value
    output logic           read_capture_q,           // capture seen, device owns bus
    output logic           ext_owned_q,              // outside master has the bus
    // pins
    output logic           bus_clock_out_q,          // bus clock
    output bus_pins_t      pins_q,                   // pins that float on grant
    output logic           pins_oe,                  // high while device drives
    input  wire logic      ack_n,                    // transfer acknowledge pin
    input  wire logic      transfer_fault_n,         // bus error pin
    input  wire logic      read_capture_enable_n,    // read capture pin
    input  wire logic      mastership_request_n,     // outside request pin
    output logic           mastership_grant_n_q      // grant pin
);
    // ------------------------------------------------------------
    // bus clock phases
    // ------------------------------------------------------------
    logic [PH_W-1:0] ph_q;
    logic            rise;
    logic            fall;
    logic            mid2;

    // two core cycles per phase leave room to drop the latch strobe first
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ph_q <= PH_RST;
        end else begin
            ph_q <= ph_q + 2'h1;
        end
    end

    // clock high through phase 1
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_clock_out_q <= 1'b0;
        end else begin
            // hold low after reset so the first high phase is a full one
            bus_clock_out_q <= (ph_q == PH_RISE) || (ph_q == PH_RST && bus_clock_out_q);
        end
    end

    assign rise = (ph_q == PH_RISE);
    assign fall = (ph_q == PH_FALL);
    assign mid2 = (ph_q == PH_MID2);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pin_s;
    logic       ack_s;
    logic       fault_s;
    logic       cap_s;
    logic       req_s;

    bit_sync #(.W(4)) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .rst_val  (4'hf),
        .d        ({ack_n, transfer_fault_n, read_capture_enable_n,
                    mastership_request_n}),
        .q        (pin_s)
    );

    assign ack_s   = !pin_s[3];
    assign fault_s = !pin_s[2];
    assign cap_s   = !pin_s[1];
    assign req_s   = !pin_s[0];

    // ------------------------------------------------------------
    // arbiter
    // ------------------------------------------------------------
    wr_state_t st_q;
    logic      grant;
    logic      start_ok;
    logic      start;

    mastership_arb u_arb (
        .core_clk (core_clk),
        .rst      (rst),
        .rise     (rise),
        .fall     (fall),
        .req      (req_s),
        .busy     (rd_active || st_q != W_IDLE),
        .grant_q  (grant),
        .drive_q  (pins_oe),
        .start_ok (start_ok)
    );

    // grant pin and ownership flag follow the arbiter one core cycle on
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mastership_grant_n_q <= 1'b1;
            ext_owned_q          <= 1'b0;
        end else begin
            mastership_grant_n_q <= !grant;
            ext_owned_q          <= grant;
        end
    end

    // capture is only meaningful while the device owns the bus
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            read_capture_q <= 1'b0;
        end else begin
            read_capture_q <= cap_s && !grant;
        end
    end

    // ------------------------------------------------------------
    // same-page hint
    // ------------------------------------------------------------
    logic [AD_W-1:0] page_q;
    logic            page_ok_q;
    logic            same_page_write_hint;

    // the outside master may open any page, so forget it on grant
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            page_q    <= '0;
            page_ok_q <= 1'b0;
        end else if (grant || rd_active) begin
            page_ok_q <= 1'b0;
        end else if (start) begin
            page_q    <= wr_req.addr >> PAGE_BIT;
            page_ok_q <= 1'b1;
        end
    end

    assign same_page_write_hint = page_ok_q && (page_q == (wr_req.addr >> PAGE_BIT));

    // ------------------------------------------------------------
    // write engine
    // ------------------------------------------------------------
    logic [AD_W-1:0] data_q;
    logic            term_s;

    // stores held over a grant go out unchanged; outside traffic is never snooped
    assign start  = start_ok && wr_valid && !rd_active && st_q == W_IDLE;
    assign term_s = (ack_s || fault_s) && !grant;

    // one store per transaction; never chained into a burst
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q   <= W_IDLE;
            data_q <= '0;
        end else begin
            case (st_q)
                W_IDLE: begin
                    if (start) begin
                        st_q   <= W_ADDR;
                        data_q <= wr_req.data;
                    end
                end
                W_ADDR: begin
                    if (fall) begin
                        st_q <= W_HOLD;
                    end
                end
                W_HOLD: begin
                    if (mid2) begin
                        st_q <= W_DATA;
                    end
                end
                W_DATA: begin
                    if (rise && term_s) begin
                        st_q <= W_TERM;
                    end
                end
                W_TERM: begin
                    if (rise) begin
                        st_q <= W_IDLE;
                    end
                end
                default: begin
                    st_q <= W_IDLE;
                end
            endcase
        end
    end

    // pin values; a fault retires exactly like an acknowledge, no retry
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pins_q <= PINS_RST;
        end else begin
            pins_q.rd_n      <= rd_strobe_n;
            pins_q.diag      <= diag_val;
            pins_q.data_en_n <= 1'b1;
            if (start) begin
                pins_q.ad           <= wr_req.addr;
                pins_q.addr_lo      <= wr_req.addr[3:2];
                pins_q.ale          <= 1'b1;
                pins_q.wr_n         <= 1'b0;
                pins_q.burst_hint_n <= !same_page_write_hint;
            end else if (st_q == W_ADDR && fall) begin
                pins_q.ale <= 1'b0;
            end else if (st_q == W_HOLD && mid2) begin
                pins_q.ad <= data_q;
            end else if (st_q == W_TERM && rise) begin
                pins_q.wr_n         <= 1'b1;
                pins_q.burst_hint_n <= 1'b1;
            end
        end
    end

    // status pulses to the write buffer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_taken_q <= 1'b0;
            wr_done_q  <= 1'b0;
            wr_fault_q <= 1'b0;
        end else begin
            wr_taken_q <= start;
            wr_done_q  <= st_q == W_TERM && rise;
            wr_fault_q <= st_q == W_DATA && rise && term_s && fault_s && !ack_s;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_addr_on_ale;
        @(posedge core_clk) disable iff (rst)
        $rose(pins_q.ale) |-> !pins_q.wr_n && pins_q.ad == $past(wr_req.addr);
    endproperty
    a_addr_on_ale: assert property (p_addr_on_ale) else $error("address not with latch");

    property p_ale_first;
        @(posedge core_clk) disable iff (rst)
        $fell(pins_q.ale) |-> $stable(pins_q.ad) ##1 pins_q.ad == data_q;
    endproperty
    a_ale_first: assert property (p_ale_first) else $error("address left before latch");

    property p_data_phase;
        @(posedge core_clk) disable iff (rst)
        $rose(pins_q.ale) |-> ##3 pins_q.ad == data_q && !pins_q.ale;
    endproperty
    a_data_phase: assert property (p_data_phase) else $error("data late");

    property p_min_write;
        @(posedge core_clk) disable iff (rst)
        $fell(pins_q.wr_n) |-> !pins_q.wr_n [*8];
    endproperty
    a_min_write: assert property (p_min_write) else $error("write under two cycles");

    property p_term;
        @(posedge core_clk) disable iff (rst)
        st_q == W_DATA && rise && term_s |-> ##5 pins_q.wr_n;
    endproperty
    a_term: assert property (p_term) else $error("write not ended");

    property p_wait;
        @(posedge core_clk) disable iff (rst)
        st_q == W_DATA && rise && !term_s |=> st_q == W_DATA;
    endproperty
    a_wait: assert property (p_wait) else $error("write ended without ack");

    property p_grant_fast;
        @(posedge core_clk) disable iff (rst)
        rise && req_s && st_q == W_IDLE && !rd_active && !grant && pins_oe
            |-> ##2 !mastership_grant_n_q;
    endproperty
    a_grant_fast: assert property (p_grant_fast) else $error("grant late");

    property p_float;
        @(posedge core_clk) disable iff (rst)
        grant |-> !pins_oe && st_q == W_IDLE;
    endproperty
    a_float: assert property (p_float) else $error("bus driven during grant");

    property p_release;
        @(posedge core_clk) disable iff (rst)
        grant && rise && !req_s |-> ##[1:3] !grant ##[1:4] pins_oe;
    endproperty
    a_release: assert property (p_release) else $error("release slow");

    property p_resume;
        @(posedge core_clk) disable iff (rst)
        $fell(grant) |-> !pins_oe ##2 pins_oe;
    endproperty
    a_resume: assert property (p_resume) else $error("drive not resumed");

    c_zero_wait: cover property (@(posedge core_clk) disable iff (rst)
        $fell(pins_q.wr_n) ##8 $rose(pins_q.wr_n));
    c_fault: cover property (@(posedge core_clk) disable iff (rst) wr_fault_q);
    c_grant: cover property (@(posedge core_clk) disable iff (rst) $fell(grant));
    c_hint: cover property (@(posedge core_clk) disable iff (rst) $fell(pins_q.burst_hint_n));
endmodule
`default_nettype wire

// ===== verilog/wbus_pkg.sv
// shared constants and carrier types for the write bus and mastership block
package wbus_pkg;
    // ------------------------------------------------------------
    // bus clock phase counting
    // ------------------------------------------------------------
    localparam int unsigned CORE_CLK_MHZ  = 125;
    localparam int unsigned PH_W          = 2;
    localparam logic [1:0]  PH_FALL       = 2'h1;  // next edge opens phase 2
    localparam logic [1:0]  PH_MID2       = 2'h2;  // next edge opens second core cycle of phase 2
    localparam logic [1:0]  PH_RISE       = 2'h3;  // next edge opens phase 1
    localparam logic [1:0]  PH_RST        = 2'h0;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int unsigned AD_W          = 32;
    localparam int unsigned PAGE_LSB      = 10;
    localparam logic [1:0]  DIAG_RST      = 2'h0;

    // write request from the write buffer
    typedef struct packed {
        logic [AD_W-1:0] addr;
        logic [AD_W-1:0] data;
    } wr_req_t;

    // pins that float while the outside master owns the bus
    typedef struct packed {
        logic [AD_W-1:0] ad;
        logic [1:0]      addr_lo;
        logic            rd_n;
        logic            wr_n;
        logic            data_en_n;
        logic            burst_hint_n;
        logic            ale;
        logic [1:0]      diag;
    } bus_pins_t;

    localparam bus_pins_t PINS_RST = '{ad: 32'h0, addr_lo: 2'h0, rd_n: 1'b1,
        wr_n: 1'b1, data_en_n: 1'b1, burst_hint_n: 1'b1, ale: 1'b0, diag: DIAG_RST};

    typedef enum logic [4:0] {
        W_IDLE = 5'h01,
        W_ADDR = 5'h02,
        W_HOLD = 5'h04,
        W_DATA = 5'h08,
        W_TERM = 5'h10
    } wr_state_t;

    typedef enum logic [3:0] {
        A_OWN  = 4'h1,
        A_GNT  = 4'h2,
        A_REL  = 4'h4,
        A_BACK = 4'h8
    } arb_state_t;
endpackage

// ===== verilog/bit_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module bit_sync
    import wbus_pkg::*;
#(
    parameter int unsigned W = 1
) (
    input  wire logic         core_clk,  // core clock
    input  wire logic         rst,       // async reset
    input  wire logic [W-1:0] rst_val,   // unused at reset, level when idle
    input  wire logic [W-1:0] d,         // asynchronous input
    output logic      [W-1:0] q          // synchronised output
);
    logic [W-1:0] meta_q;

    // ------------------------------------------------------------
    // stages
    // ------------------------------------------------------------
    // reset to all ones: the pins are active low, so idle means negated
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_q <= '1;
            q      <= '1;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

    logic unused_ok;
    assign unused_ok = ^rst_val;
endmodule
`default_nettype wire

// ===== verilog/mastership_arb.sv
// bus mastership arbiter for the outside request
`timescale 1ns/1ps
`default_nettype none
module mastership_arb
    import wbus_pkg::*;
(
    input  wire logic core_clk,   // core clock
    input  wire logic rst,        // async reset
    input  wire logic rise,       // next edge is a bus clock rising edge
    input  wire logic fall,       // next edge is a bus clock falling edge
    input  wire logic req,        // synchronised request, active high
    input  wire logic busy,       // read or write owns the bus
    output logic      grant_q,    // grant, active high
    output logic      drive_q,    // device drives its bus pins
    output logic      start_ok    // a write may open on this rising edge
);
    arb_state_t st_q;

    // ------------------------------------------------------------
    // ownership sequence
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q    <= A_OWN;
            grant_q <= 1'b0;
            drive_q <= 1'b1;
        end else begin
            case (st_q)
                A_OWN: begin
                    if (rise && req && !busy) begin
                        st_q    <= A_GNT;
                        grant_q <= 1'b1;
                        drive_q <= 1'b0;
                    end
                end
                A_GNT: begin
                    if (rise && !req) begin
                        st_q <= A_REL;
                    end
                end
                A_REL: begin
                    if (fall) begin
                        st_q    <= A_BACK;
                        grant_q <= 1'b0;
                    end
                end
                A_BACK: begin
                    if (rise) begin
                        st_q    <= A_OWN;
                        drive_q <= 1'b1;
                    end
                end
                default: begin
                    st_q <= A_OWN;
                end
            endcase
        end
    end

    // request wins over a waiting write on the same edge
    assign start_ok = rise && !req && (st_q == A_OWN || st_q == A_BACK);
endmodule
`default_nettype wire

// ===== tb/mem_dma_model.sv
// memory controller and outside bus master model facing the write port
`timescale 1ns/1ps
`default_nettype none
module mem_dma_model
    import wbus_pkg::*;
(
    input  wire logic       core_clk,   // core clock
    input  wire logic       rst,        // async reset
    input  wire logic       bus_clk,    // bus clock from the device
    input  wire logic       wr_n,       // device write strobe
    input  wire logic       grant_n,    // device grant pin
    input  wire logic [3:0] waits,      // bus rises to let pass first
    input  wire logic       use_fault,  // end writes with a fault
    input  wire logic       dma_go,     // bench wants the bus
    input  wire logic       cap_go,     // bench wants a capture strobe
    output logic            ack_n,      // acknowledge pin
    output logic            fault_n,    // fault pin
    output logic            cap_n,      // read capture pin
    output logic            req_n       // mastership request pin
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic       clk_d_q;  // bus clock one core cycle ago
    logic [3:0] rises_q;  // bus rises seen in this write
    logic       dma_on;   // outside master runs its own traffic

    // own traffic stops the moment the request drops
    assign dma_on = dma_go && !grant_n;

    // ------------------------------------------------------------
    // terminations and own traffic
    // ------------------------------------------------------------
    // terminations held to write end; no address decode, so claims at once
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clk_d_q <= 1'b0;
            rises_q <= 4'h0;
            ack_n   <= 1'b1;
            fault_n <= 1'b1;
            cap_n   <= 1'b1;
            req_n   <= 1'b1;
        end else begin
            clk_d_q <= bus_clk;
            req_n   <= !dma_go;
            if (dma_on) begin
                // one word every two core clocks; device must ignore these strobes
                ack_n   <= !ack_n;
                fault_n <= ack_n;
                cap_n   <= !cap_n;
            end else if (wr_n) begin
                rises_q <= 4'h0;
                ack_n   <= 1'b1;
                fault_n <= 1'b1;
                cap_n   <= !cap_go;
            end else begin
                if (bus_clk && !clk_d_q) begin
                    rises_q <= rises_q + 4'h1;
                end
                ack_n   <= !(rises_q >= waits && !use_fault);
                fault_n <= !(rises_q >= waits && use_fault);
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the write port and mastership hand-off
`timescale 1ns/1ps
`default_nettype none
module tb
    import wbus_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       wr_valid = 1'b0;
    wr_req_t    wr_req = '0;
    logic       rd_active = 1'b0;
    logic       rd_strobe_n = 1'b1;
    logic [1:0] diag_val = 2'h0;
    logic [3:0] waits = 4'h0;
    logic       use_fault = 1'b0;
    logic       dma_go = 1'b0;
    logic       cap_go = 1'b0;
    logic       wr_taken_q, wr_done_q, wr_fault_q, read_capture_q, ext_owned_q;
    logic       bus_clock_out_q, pins_oe, ack_n, fault_n, cap_n, req_n, grant_n;
    bus_pins_t  pins_q;
    int         mismatches = 0;
    int         checks = 0;
    int         i;

    always #4 core_clk = ~core_clk;

    wbus_write_port #(.PAGE_BIT(10)) dut (
        .core_clk(core_clk), .rst(rst), .wr_valid(wr_valid), .wr_req(wr_req),
        .wr_taken_q(wr_taken_q), .wr_done_q(wr_done_q), .wr_fault_q(wr_fault_q),
        .rd_active(rd_active), .rd_strobe_n(rd_strobe_n), .diag_val(diag_val),
        .read_capture_q(read_capture_q), .ext_owned_q(ext_owned_q),
        .bus_clock_out_q(bus_clock_out_q), .pins_q(pins_q), .pins_oe(pins_oe),
        .ack_n(ack_n), .transfer_fault_n(fault_n), .read_capture_enable_n(cap_n),
        .mastership_request_n(req_n), .mastership_grant_n_q(grant_n));

    mem_dma_model mem (
        .core_clk(core_clk), .rst(rst), .bus_clk(bus_clock_out_q), .wr_n(pins_q.wr_n),
        .grant_n(grant_n), .waits(waits), .use_fault(use_fault), .dma_go(dma_go),
        .cap_go(cap_go), .ack_n(ack_n), .fault_n(fault_n), .cap_n(cap_n), .req_n(req_n));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // sample one core cycle later, clear of the edge's updates
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // one store, walked cycle by cycle from the opening rise; hint 2 skips the hint
    task automatic do_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] w,
                            input logic f, input logic [1:0] hint, input logic mid);
        int n;
        @(posedge core_clk);
        waits     <= w;
        use_fault <= f;
        wr_req    <= '{addr: a, data: d};
        wr_valid  <= 1'b1;
        for (n = 0; n < 64 && pins_q.wr_n !== 1'b0; n++) tick();
        chk({pins_q.ale, pins_q.ad}, {1'b1, a});
        chk(pins_q.addr_lo, a[3:2]);
        if (hint != 2'h2) chk(pins_q.burst_hint_n, hint[0]);
        chk(wr_taken_q, 1'b1);
        n = 0;
        while (n < 200 && wr_done_q !== 1'b1) begin
            @(posedge core_clk);
            if (n == 0) wr_valid <= 1'b0;
            if (n == 0 && mid) dma_go <= 1'b1;
            #1;
            n++;
            if (n == 1) chk(wr_taken_q, 1'b0);
            if (n == 4 + 4 * w) chk(wr_fault_q, f);
            if (n == 2) chk({pins_q.ale, pins_q.ad}, {1'b0, a});
            if (n == 3) chk(pins_q.ad, d);
            if (mid) chk(grant_n, 1'b1);
        end
        chk(64'(n), 64'(8 + 4 * w));
        chk({pins_q.wr_n, wr_fault_q}, {1'b1, 1'b0});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // back-to-back stores: waits, page hint both ways, a fault with no retry
    task automatic t_writes();
        do_write(32'h1000_0010, 32'ha5a5_0001, 4'h0, 1'b0, 2'h2, 1'b0);
        do_write(32'h1000_0014, 32'h5a5a_0002, 4'h1, 1'b0, 2'h0, 1'b0);
        do_write(32'h1000_0414, 32'h0f0f_0003, 4'h2, 1'b0, 2'h1, 1'b0);
        do_write(32'h1000_0418, 32'hf0f0_0004, 4'h0, 1'b1, 2'h0, 1'b0);
        for (i = 0; i < 12; i++) begin
            tick();
            chk(pins_q.wr_n, 1'b1);
        end
    endtask

    // a read holds off a pending store; strobe, diag and capture pass through
    task automatic t_read_side();
        @(posedge core_clk);
        rd_active   <= 1'b1;
        rd_strobe_n <= 1'b0;
        diag_val    <= 2'h2;
        cap_go      <= 1'b1;
        wr_valid    <= 1'b1;
        for (i = 0; i < 16; i++) tick();
        chk({pins_q.wr_n, pins_q.data_en_n, pins_q.rd_n, pins_q.diag, read_capture_q},
            6'h35);
        @(posedge core_clk);
        rd_active   <= 1'b0;
        rd_strobe_n <= 1'b1;
        cap_go      <= 1'b0;
        wr_valid    <= 1'b0;
        for (i = 0; i < 8; i++) tick();
    endtask

    // grant from idle wins over a store; hand-back opens the store at once
    task automatic t_dma_idle();
        @(posedge core_clk) dma_go <= 1'b1;
        for (i = 0; i < 4; i++) tick();
        @(posedge core_clk);
        wr_req   <= '{addr: 32'h2000_0020, data: 32'h1234_5678};
        wr_valid <= 1'b1;
        for (i = 0; i < 40 && grant_n !== 1'b0; i++) tick();
        chk({grant_n, pins_oe, ext_owned_q}, 3'h1);
        for (i = 0; i < 24; i++) begin
            tick();
            chk({wr_taken_q, wr_done_q, read_capture_q, pins_oe}, 4'h0);
        end
        @(posedge core_clk) dma_go <= 1'b0;
        for (i = 0; i < 40 && grant_n !== 1'b1; i++) tick();
        chk({grant_n, bus_clock_out_q, pins_oe}, 3'h4);
        for (i = 0; i < 8 && pins_oe !== 1'b1; i++) tick();
        chk({pins_oe, bus_clock_out_q, pins_q.wr_n}, 3'h6);
        @(posedge core_clk) wr_valid <= 1'b0;
        for (i = 0; i < 40 && wr_done_q !== 1'b1; i++) tick();
        chk(wr_done_q, 1'b1);
    endtask

    // request arrives mid-write: grant only after the write retires
    task automatic t_dma_mid();
        do_write(32'h3000_0040, 32'hcafe_0005, 4'h2, 1'b0, 2'h2, 1'b1);
        for (i = 0; i < 12 && grant_n !== 1'b0; i++) tick();
        chk(grant_n, 1'b0);
        @(posedge core_clk) dma_go <= 1'b0;
        for (i = 0; i < 40 && pins_oe !== 1'b1; i++) tick();
        chk({pins_oe, grant_n}, 2'h3);
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        tick();
        chk({pins_oe, grant_n, pins_q.wr_n, pins_q.ale}, 4'he);
        t_writes();
        t_read_side();
        t_dma_idle();
        t_dma_mid();
        close_out();
    end

    // whole run is a few hundred cycles; this is far beyond it
    initial begin
        #100000;
        mismatches++;
        close_out();
    end
endmodule
`default_nettype wire
